// ===== core/tmr2_defs.vh
`ifndef TMR2_DEFS_VH
`define TMR2_DEFS_VH
// ---------------------------------------------------------------
// register byte addresses on apb
// ---------------------------------------------------------------
`define TMR2_CTRL_ADDR      8'hc8
`define TMR2_MODE_ADDR      8'hc9
`define TMR2_RELOAD_LO_ADDR 8'hca
`define TMR2_RELOAD_HI_ADDR 8'hcb
`define TMR2_COUNT_LO_ADDR  8'hcc
`define TMR2_COUNT_HI_ADDR  8'hcd
`define TMR2_STATUS_ADDR    8'hd0
// ---------------------------------------------------------------
// control and mode field positions
// ---------------------------------------------------------------
`define TMR2_OVF_BIT   7
`define TMR2_EXF_BIT   6
`define TMR2_RXSEL_BIT 5
`define TMR2_TXSEL_BIT 4
`define TMR2_EXEN_BIT  3
`define TMR2_RUN_BIT   2
`define TMR2_CSRC_BIT  1
`define TMR2_CPRL_BIT  0
`define TMR2_DOWN_COUNT_ENABLE_BIT  0
// ---------------------------------------------------------------
// reset values, timing and status mode codes
// ---------------------------------------------------------------
`define TMR2_CTRL_RST  8'h00
`define TMR2_MODE_RST  8'h00
`define TMR2_BYTE_RST  8'h00
`define TMR2_OSC_PER_MC 12
`define TMR2_OSC_PER_ST 2
`define TMR2_MODE_OFF   2'h0
`define TMR2_MODE_RLD   2'h1
`define TMR2_MODE_CAP   2'h2
`define TMR2_MODE_BAUD  2'h3
`endif

// ===== core/tmr2_core.v
// Summary of operation
// - overflow_flag set on 16-bit overflow; only software write clears it.
// - overflow_flag never set while either baud source select is 1.
// - external_edge_flag set when trigger edge causes capture or reload, enabled.
// - irq from external_edge_flag when enabled, masked when down_count_enable set.
// - rx baud tick uses this timer's overflow when rx select is 1.
// - tx baud tick uses this timer's overflow when tx select is 1.
// - trigger edges act only when enabled and not clocking serial port.
// - counting only while run_control is 1.
// - count_source_sel: 0 machine cycles (state times in baud mode), 1 count_input falling edges.
// - capture_reload_sel 1 captures on trigger, 0 reloads on overflow/trigger.
// - in baud mode always auto-reload on overflow.
// - mode decoded: off, auto-reload, capture, baud generator.
// - timer function increments once per machine cycle of 12 oscillator periods.
// - count_input sampled once per machine cycle; high then low counts.
// - counted edge shows in the count two machine cycles after detection.
// - capture mode without trigger is plain 16-bit timer with overflow flag.
// - capture copies count bytes into reload pair and sets external_edge_flag.
// - count held as two software-readable 8-bit bytes.
// - trigger_input and count_input arrive on separate pins.
// - auto-reload overflow loads count from the capture/reload pair.
// - irq is or of both flags, external_edge_flag masked by down_count_enable; vectoring clears neither.
//
// Our own choice: register access over APB.
`include "tmr2_defs.vh"
`default_nettype none
module tmr2_core #(
  parameter integer OSC_PER_CLK = 1
) (
  input  wire        clk,
  input  wire        rstn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        count_input,
  input  wire        trigger_input,
  input  wire        irq_enable,
  output reg         timer_irq,
  output reg         rx_baud_tick,
  output reg         tx_baud_tick,
  output reg         count_tick
);
  // ---------------------------------------------------------------
  // prescalers: machine cycle and state time enables
  // ---------------------------------------------------------------
  localparam integer MC_CLKS = (`TMR2_OSC_PER_MC + OSC_PER_CLK - 1) / OSC_PER_CLK;
  localparam integer ST_CLKS = (`TMR2_OSC_PER_ST + OSC_PER_CLK - 1) / OSC_PER_CLK;
  reg  [7:0]  mc_cnt_ff;
  reg  [7:0]  st_cnt_ff;
  wire        mc_en;
  wire        st_en;
  assign mc_en = (mc_cnt_ff == MC_CLKS[7:0] - 8'h01);
  assign st_en = (st_cnt_ff == ST_CLKS[7:0] - 8'h01);
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mc_cnt_ff <= 8'h00;
      st_cnt_ff <= 8'h00;
    end else begin
      mc_cnt_ff <= mc_en ? 8'h00 : mc_cnt_ff + 8'h01;
      st_cnt_ff <= st_en ? 8'h00 : st_cnt_ff + 8'h01;
    end
  end
  // ---------------------------------------------------------------
  // pin synchronisers and per machine cycle samples
  // ---------------------------------------------------------------
  reg  [1:0]  cnt_sync_ff;
  reg  [1:0]  trg_sync_ff;
  reg  [1:0]  cnt_smp_ff;
  reg  [1:0]  trg_smp_ff;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_sync_ff <= 2'h3;
      trg_sync_ff <= 2'h3;
      cnt_smp_ff  <= 2'h3;
      trg_smp_ff  <= 2'h3;
    end else begin
      cnt_sync_ff <= {cnt_sync_ff[0], count_input};
      trg_sync_ff <= {trg_sync_ff[0], trigger_input};
      if (mc_en) begin
        cnt_smp_ff <= {cnt_smp_ff[0], cnt_sync_ff[1]};
        trg_smp_ff <= {trg_smp_ff[0], trg_sync_ff[1]};
      end
    end
  end
  // fall seen in the sample pair; acted on at the next machine cycle
  wire cnt_fall;
  wire trg_fall;
  assign cnt_fall = cnt_smp_ff[1] & ~cnt_smp_ff[0];
  assign trg_fall = trg_smp_ff[1] & ~trg_smp_ff[0];
  reg  cnt_pend_ff;
  reg  trg_pend_ff;
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg  [7:0]  ctrl_ff;
  reg  [7:0]  mode_ff;
  reg  [7:0]  rld_lo_ff;
  reg  [7:0]  rld_hi_ff;
  reg  [7:0]  cnt_lo_ff;
  reg  [7:0]  cnt_hi_ff;
  wire        run     = ctrl_ff[`TMR2_RUN_BIT];
  wire        exen    = ctrl_ff[`TMR2_EXEN_BIT];
  wire        csrc    = ctrl_ff[`TMR2_CSRC_BIT];
  wire        cprl    = ctrl_ff[`TMR2_CPRL_BIT];
  wire        rxsel   = ctrl_ff[`TMR2_RXSEL_BIT];
  wire        txsel   = ctrl_ff[`TMR2_TXSEL_BIT];
  wire        baud    = rxsel | txsel;
  wire        down_count_enable    = mode_ff[`TMR2_DOWN_COUNT_ENABLE_BIT];

  function [1:0] decode_mode;
    input r;
    input b;
    input c;
    begin
      if (!r)
        decode_mode = `TMR2_MODE_OFF;
      else if (b)
        decode_mode = `TMR2_MODE_BAUD;
      else if (c)
        decode_mode = `TMR2_MODE_CAP;
      else
        decode_mode = `TMR2_MODE_RLD;
    end
  endfunction
  wire [1:0]  mode = decode_mode(run, baud, cprl);

  // pin edges when count_source_sel is 1; else baud generator times on state time, otherwise machine cycle
  wire        inc = (mode != `TMR2_MODE_OFF) &&
                    (csrc ? cnt_pend_ff && mc_en
                          : (baud ? st_en : mc_en));
  wire [16:0] cnt_sum = {1'b0, cnt_hi_ff, cnt_lo_ff} + 17'h00001;
  wire        ovf = inc & cnt_sum[16];
  // trigger acts only when enabled; in baud mode it only flags
  wire        trg_evt = exen && trg_pend_ff && mc_en;
  wire        trg_act = trg_evt && !baud && run;

  // ---------------------------------------------------------------
  // apb slave: zero wait states, unmapped address errors
  // ---------------------------------------------------------------
  wire        acc    = psel & penable;
  wire        wr     = acc & pwrite;
  wire [7:0]  a      = paddr[7:0];
  wire        mapped = (paddr[31:8] == 24'h000000) &&
                       (a == `TMR2_CTRL_ADDR || a == `TMR2_MODE_ADDR ||
                        a == `TMR2_RELOAD_LO_ADDR || a == `TMR2_RELOAD_HI_ADDR ||
                        a == `TMR2_COUNT_LO_ADDR || a == `TMR2_COUNT_HI_ADDR ||
                        a == `TMR2_STATUS_ADDR);
  wire        wr_ctrl = wr && mapped && a == `TMR2_CTRL_ADDR;
  wire        wr_mode = wr && mapped && a == `TMR2_MODE_ADDR;
  wire        wr_rlo  = wr && mapped && a == `TMR2_RELOAD_LO_ADDR;
  wire        wr_rhi  = wr && mapped && a == `TMR2_RELOAD_HI_ADDR;
  wire        wr_clo  = wr && mapped && a == `TMR2_COUNT_LO_ADDR;
  wire        wr_chi  = wr && mapped && a == `TMR2_COUNT_HI_ADDR;

  reg  [7:0]  rd_mux;
  always @* begin
    case (a)
      `TMR2_CTRL_ADDR:      rd_mux = ctrl_ff;
      `TMR2_MODE_ADDR:      rd_mux = {7'h00, down_count_enable};
      `TMR2_RELOAD_LO_ADDR: rd_mux = rld_lo_ff;
      `TMR2_RELOAD_HI_ADDR: rd_mux = rld_hi_ff;
      `TMR2_COUNT_LO_ADDR:  rd_mux = cnt_lo_ff;
      `TMR2_COUNT_HI_ADDR:  rd_mux = cnt_hi_ff;
      `TMR2_STATUS_ADDR:    rd_mux = {6'h00, mode};
      default:              rd_mux = 8'h00;
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite & mapped) ? {24'h000000, rd_mux} : 32'h00000000;
    end
  end
  // pready is registered from the setup cycle, so the write lands in the
  // access cycle edge where pready is already high
  wire        wr_ok = pready;

  // ---------------------------------------------------------------
  // counter, reload pair, control and flags
  // ---------------------------------------------------------------
  reg  [7:0]  nxt_ctrl;
  always @* begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl && wr_ok)
      nxt_ctrl = pwdata[7:0];
    if (ovf && !baud)
      nxt_ctrl[`TMR2_OVF_BIT] = 1'b1;
    if (trg_evt && run)                                         // set beats clear
      nxt_ctrl[`TMR2_EXF_BIT] = 1'b1;
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff     <= `TMR2_CTRL_RST;
      mode_ff     <= `TMR2_MODE_RST;
      rld_lo_ff   <= `TMR2_BYTE_RST;
      rld_hi_ff   <= `TMR2_BYTE_RST;
      cnt_lo_ff   <= `TMR2_BYTE_RST;
      cnt_hi_ff   <= `TMR2_BYTE_RST;
      cnt_pend_ff <= 1'b0;
      trg_pend_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      if (wr_mode && wr_ok)
        mode_ff <= {7'h00, pwdata[`TMR2_DOWN_COUNT_ENABLE_BIT]};
      if (mc_en) begin
        cnt_pend_ff <= cnt_fall;
        trg_pend_ff <= trg_fall;
      end
      // capture: software write to reload pair loses to hardware capture
      if (trg_act && mode == `TMR2_MODE_CAP) begin
        rld_lo_ff <= cnt_lo_ff;
        rld_hi_ff <= cnt_hi_ff;
      end else begin
        if (wr_rlo && wr_ok)
          rld_lo_ff <= pwdata[7:0];
        if (wr_rhi && wr_ok)
          rld_hi_ff <= pwdata[7:0];
      end
      if ((ovf && mode != `TMR2_MODE_CAP) ||
          (trg_act && mode == `TMR2_MODE_RLD)) begin
        cnt_lo_ff <= rld_lo_ff;
        cnt_hi_ff <= rld_hi_ff;
      end else if (inc) begin
        cnt_lo_ff <= cnt_sum[7:0];
        cnt_hi_ff <= cnt_sum[15:8];
      end else begin
        if (wr_clo && wr_ok)
          cnt_lo_ff <= pwdata[7:0];
        if (wr_chi && wr_ok)
          cnt_hi_ff <= pwdata[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timer_irq    <= 1'b0;
      rx_baud_tick <= 1'b0;
      tx_baud_tick <= 1'b0;
      count_tick   <= 1'b0;
    end else begin
      // flags stay set; the interrupt level persists until software clears
      timer_irq    <= irq_enable & (nxt_ctrl[`TMR2_OVF_BIT] |
                      (nxt_ctrl[`TMR2_EXF_BIT] & ~down_count_enable));
      rx_baud_tick <= ovf & rxsel;
      tx_baud_tick <= ovf & txsel;
      count_tick   <= ovf;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/tmr2_core_properties.sv
`default_nettype none
module tmr2_core_properties #(parameter integer OSC_PER_CLK = 1) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq_enable,
  input wire logic        timer_irq,
  input wire logic        rx_baud_tick,
  input wire logic        tx_baud_tick,
  input wire logic        count_tick
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_ready_setup: assert property (psel && !penable |=> pready) else $error("no ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_err_unmapped: assert property (psel && !penable && paddr[31:8] != 24'h0 |=> pslverr) else $error("no error");
  a_data_upper: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper data set");
  a_irq_masked: assert property (!irq_enable |=> !timer_irq) else $error("masked irq");
  a_rx_cause: assert property (rx_baud_tick |-> count_tick) else $error("stray rx tick");
  a_tx_cause: assert property (tx_baud_tick |-> count_tick) else $error("stray tx tick");
  a_tick_pulse: assert property (count_tick |=> !count_tick) else $error("tick held");
endmodule
bind tmr2_core tmr2_core_properties #(.OSC_PER_CLK(OSC_PER_CLK)) tmr2_core_properties_inst (.clk, .rstn, .psel,
  .penable, .paddr, .prdata, .pready, .pslverr, .irq_enable, .timer_irq, .rx_baud_tick, .tx_baud_tick, .count_tick);
`default_nettype wire

// ===== testbench/tmr2_pins.sv
`default_nettype none
module tmr2_pins (
  input  wire logic clk,
  output wire logic count_input,
  output wire logic trigger_input
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] lvl = 2'b11;
  assign count_input = lvl[0];
  assign trigger_input = lvl[1];
  // idle high like pulled-up port pins; two machine cycles per level so no level is missed
  task fall(input int k);
    lvl[k] <= 1'b0;
    repeat (24) @(posedge clk);
    lvl[k] <= 1'b1;
    repeat (24) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ===== testbench/tmr2_core_bench.sv
`include "tmr2_defs.vh"
`default_nettype none
module tmr2_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, irq_en = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rdat;
  logic        pready, pslverr, irq, rxt, txt, tick, cin, trg, rerr;
  logic [7:0]  md[4] = '{8'h00, 8'h04, 8'h05, 8'h14}, cfg[3] = '{8'h34, 8'h24, 8'h14};
  int          err_total = 0, n_tests = 0, cyc = 0;
  tmr2_core tmr2_core_inst (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .count_input(cin), .trigger_input(trg), .irq_enable(irq_en), .timer_irq(irq), .rx_baud_tick(rxt),
    .tx_baud_tick(txt), .count_tick(tick));
  tmr2_pins tmr2_pins_inst (.clk(clk), .count_input(cin), .trigger_input(trg));
  initial forever #25 clk = ~clk;
  always @(posedge clk)
    if (++cyc == 5000) stop_test(1'b1);
  task stop_test(input bit hung);
    err_total += hung;
    if (err_total == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) err_total++;
    if (got !== exp) $display("wrong value at %0t: got %h expected %h", $time, got, exp);
  endtask
  // request held until ready is seen at an edge; one idle cycle between transfers
  task apb(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    {rerr, rdat} = {pslverr, prdata};
    {psel, penable} <= 2'b00;
  endtask
  task wr16(input logic [31:0] a, input logic [15:0] v);
    apb(1'b1, a, v[7:0]);
    apb(1'b1, a + 1, v[15:8]);
  endtask
  task rd(input logic [31:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rdat, {24'h0, e});
  endtask
  task wait_tick;
    do @(posedge clk); while (tick !== 1'b1);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rd(`TMR2_CTRL_ADDR, 8'h00);
    apb(1'b0, 32'h1c8, 8'h00);
    chk(rerr, 1'b1);
    wr16(`TMR2_RELOAD_LO_ADDR, 16'h1234);
    wr16(`TMR2_COUNT_LO_ADDR, 16'hfffe);
    apb(1'b1, `TMR2_CTRL_ADDR, 8'h04);
    wait_tick;
    rd(`TMR2_CTRL_ADDR, 8'h84);
    apb(1'b1, `TMR2_CTRL_ADDR, 8'h80);
    rd(`TMR2_COUNT_LO_ADDR, 8'h34);
    rd(`TMR2_COUNT_HI_ADDR, 8'h12);
    irq_en <= 1'b1;
    repeat (3) @(posedge clk);
    chk(irq, 1'b1);
    wr16(`TMR2_COUNT_LO_ADDR, 16'h00ff);
    apb(1'b1, `TMR2_CTRL_ADDR, 8'h06);
    @(posedge clk);
    chk(irq, 1'b0);
    repeat (3) tmr2_pins_inst.fall(0);
    tmr2_pins_inst.fall(1);
    rd(`TMR2_CTRL_ADDR, 8'h06);
    rd(`TMR2_COUNT_LO_ADDR, 8'h02);
    apb(1'b1, `TMR2_CTRL_ADDR, 8'h0f);
    tmr2_pins_inst.fall(1);
    rd(`TMR2_RELOAD_LO_ADDR, 8'h02);
    rd(`TMR2_RELOAD_HI_ADDR, 8'h01);
    rd(`TMR2_CTRL_ADDR, 8'h4f);
    apb(1'b1, `TMR2_COUNT_HI_ADDR, 8'h77);
    apb(1'b1, `TMR2_CTRL_ADDR, 8'h0e);
    tmr2_pins_inst.fall(1);
    rd(`TMR2_COUNT_HI_ADDR, 8'h01);
    rd(`TMR2_CTRL_ADDR, 8'h4e);
    apb(1'b1, `TMR2_MODE_ADDR, 8'h01);
    rd(`TMR2_MODE_ADDR, 8'h01);
    chk(irq, 1'b0);
    apb(1'b1, `TMR2_MODE_ADDR, 8'h00);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    wr16(`TMR2_RELOAD_LO_ADDR, 16'hfff0);
    apb(1'b1, `TMR2_COUNT_HI_ADDR, 8'hff);
    foreach (md[i]) begin
      apb(1'b1, `TMR2_CTRL_ADDR, md[i]);
      rd(`TMR2_STATUS_ADDR, 8'(i));
    end
    foreach (cfg[i]) begin
      apb(1'b1, `TMR2_CTRL_ADDR, cfg[i]);
      wait_tick;
      chk(rxt, cfg[i][5]);
      chk(txt, cfg[i][4]);
      wait_tick;
      rd(`TMR2_CTRL_ADDR, cfg[i]);
    end
    stop_test(1'b0);
  end
endmodule
`default_nettype wire
